// ==== src/ifmu_pkg.sv ====
// Purpose: Shared constants of the interrupt flag and mask unit.
// Assumes: Registers are four bits wide, one per aligned 32-bit word.
// Notes: Register indices are printed nibble addresses; byte address is 4x.
package ifmu_pkg;

    // Register indices; the byte address is the index shifted left by two.
    localparam logic [15:0] IDX_WDT_CTRL = 16'hffe0;
    localparam logic [15:0] IDX_STATUS = 16'hffe1;
    localparam logic [15:0] IDX_MASK_PT = 16'hffe2;
    localparam logic [15:0] IDX_MASK_SIF = 16'hffe3;
    localparam logic [15:0] IDX_MASK_K0 = 16'hffe4;
    localparam logic [15:0] IDX_MASK_K12 = 16'hffe5;
    localparam logic [15:0] IDX_MASK_CT = 16'hffe6;
    localparam logic [15:0] IDX_MASK_AD = 16'hffe7;
    localparam logic [15:0] IDX_FLAG_PT = 16'hfff2;
    localparam logic [15:0] IDX_FLAG_SIF = 16'hfff3;
    localparam logic [15:0] IDX_FLAG_K0 = 16'hfff4;
    localparam logic [15:0] IDX_FLAG_K12 = 16'hfff5;
    localparam logic [15:0] IDX_FLAG_CT = 16'hfff6;
    localparam logic [15:0] IDX_FLAG_AD = 16'hfff7;

    // Byte address bits that carry the register index.
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 17;

    // Positions inside the packed vector of all eleven request flags.
    localparam int NUM_FLAGS = 11;
    localparam int FV_PT = 0;
    localparam int FV_SIF = 2;
    localparam int FV_K0 = 3;
    localparam int FV_K1 = 4;
    localparam int FV_K20 = 5;
    localparam int FV_CT = 6;
    localparam int FV_AD = 10;

    // Watchdog control and status bit positions.
    localparam int WDC_ENABLE = 0;
    localparam int WDC_RESTART = 1;
    localparam int ST_SP_WIDE = 0;
    localparam int ST_SP_NIBBLE = 1;
    localparam int ST_IE = 2;
    localparam int ST_NMI = 3;

    // Reset values.
    localparam logic RST_MASK = 1'b0;
    localparam logic RST_WDT_EN = 1'b1;

    // Vectors: watchdog first, then six maskable groups two apart.
    localparam int NUM_GROUPS = 6;
    localparam logic [15:0] VEC_WDT = 16'h0100;
    localparam logic [15:0] VEC_FIRST = 16'h0104;
    localparam logic [15:0] VEC_STEP = 16'h0002;

    // Watchdog period.
    localparam int unsigned WDT_TIMEOUT_MS = 3000;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned WDT_CYCLES = WDT_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int WDT_CNT_W = 30;

endpackage

// ==== src/ifmu_flag_bank.sv ====
// Purpose: Bank of sticky request flags with write-one-to-clear.
// Assumes: Set and clear are one-cycle pulses on hclk.
// Notes: A set in the same cycle as a clear leaves the flag set.
`timescale 1ns/1ps
module ifmu_flag_bank #(
    parameter int WIDTH = 11
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] set_evt,
    input wire logic [WIDTH-1:0] clr_w1c,
    output logic [WIDTH-1:0] flags
);
    typedef struct packed {
        logic [WIDTH-1:0] f;
    } ifmu_bank_state_t;

    ifmu_bank_state_t s;
    ifmu_bank_state_t next_s;

    always_comb begin
        next_s = s;
        for (int i = 0; i < WIDTH; i++) begin
            // set regardless of mask; set beats clear.
            next_s.f[i] = set_evt[i] | (s.f[i] & ~clr_w1c[i]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign flags = s.f;
endmodule

// ==== src/ifmu_vector_sel.sv ====
// Purpose: Fixed-priority choice of the interrupt vector.
// Assumes: Group 0 is the highest maskable group.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module ifmu_vector_sel #(
    parameter int GROUPS = 6
) (
    input wire logic nmi,
    input wire logic [GROUPS-1:0] grp,
    output logic any,
    output logic [15:0] vec
);
    always_comb begin
        any = nmi | (|grp);
        vec = ifmu_pkg::VEC_WDT;
        // lowest group checked first, so higher ones override.
        for (int i = GROUPS - 1; i >= 0; i--) begin
            if (grp[i]) begin
                vec = ifmu_pkg::VEC_FIRST
                    + 16'(i) * ifmu_pkg::VEC_STEP;
            end
        end
        if (nmi) begin
            vec = ifmu_pkg::VEC_WDT;
        end
    end
endmodule

// ==== src/ifmu_top.sv ====
// Purpose: Interrupt flags, masks, watchdog request and vectoring.
// Assumes: Source events and core strobes are one-cycle pulses on hclk.
// Notes: AHB-Lite slave with zero wait states and OKAY responses only.
`timescale 1ns/1ps
module ifmu_top #(
    parameter int unsigned WDT_CYCLES = ifmu_pkg::WDT_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [1:0] prog_timer_evt,
    input wire logic serial_link_evt,
    input wire logic key_group0_evt,
    input wire logic key_group1_evt,
    input wire logic key_input20_evt,
    input wire logic [3:0] clock_tap_evt,
    input wire logic converter_evt,
    input wire logic wide_stack_pointer_wr,
    input wire logic nibble_stack_pointer_wr,
    input wire logic ie_set,
    input wire logic ie_clr,
    input wire logic return_from_handler,
    input wire logic irq_ack,
    output logic irq_req,
    output logic [15:0] irq_vector,
    output logic ie_flag
);
    localparam int CW = ifmu_pkg::WDT_CNT_W;
    localparam int NF = ifmu_pkg::NUM_FLAGS;
    localparam int NG = ifmu_pkg::NUM_GROUPS;
    localparam logic [CW-1:0] WDT_LAST = CW'(WDT_CYCLES - 1);

    typedef struct packed {
        logic dsel;
        logic dwrite;
        logic [15:0] didx;
        logic [1:0] prog_timer_mask;
        logic serial_link_mask;
        logic key_group0_mask;
        logic key_group1_mask;
        logic key_input20_mask;
        logic [3:0] clock_tap_masks;
        logic converter_mask;
        logic wdt_en;
        logic [CW-1:0] wdt_cnt;
        logic nmi_pend;
        logic sp_wide_set;
        logic sp_nib_set;
        logic ie;
        logic req;
        logic [15:0] vec;
    } ifmu_top_state_t;

    ifmu_top_state_t s;
    ifmu_top_state_t next_s;

    logic [NF-1:0] flags;
    logic [NF-1:0] flag_set;
    logic [NF-1:0] flag_clr;
    logic [NF-1:0] mask_vec;
    logic [NF-1:0] live;
    logic [NG-1:0] grp;
    logic nmi_live;
    logic sel_any;
    logic [15:0] sel_vec;
    logic wr_go;
    logic [3:0] wd;

    // Decode used by both the write path and the read mux.
    function automatic logic hit(input logic [15:0] idx,
                                 input logic [15:0] reg_idx);
        return idx == reg_idx;
    endfunction

    assign wr_go = s.dsel & s.dwrite;
    assign wd = hwdata[3:0];

    // events go straight to the flags, ignoring masks.
    assign flag_set = {converter_evt, clock_tap_evt, key_input20_evt,
                       key_group1_evt, key_group0_evt, serial_link_evt,
                       prog_timer_evt};

    // write one clears the addressed flags, zero is ignored.
    always_comb begin
        flag_clr = '0;
        if (wr_go) begin
            // timer flags at bits 1 and 0.
            if (hit(s.didx, ifmu_pkg::IDX_FLAG_PT)) begin
                flag_clr[ifmu_pkg::FV_PT +: 2] = wd[1:0];
            end
            if (hit(s.didx, ifmu_pkg::IDX_FLAG_SIF)) begin
                flag_clr[ifmu_pkg::FV_SIF] = wd[0];
            end
            if (hit(s.didx, ifmu_pkg::IDX_FLAG_K0)) begin
                flag_clr[ifmu_pkg::FV_K0] = wd[0];
            end
            if (hit(s.didx, ifmu_pkg::IDX_FLAG_K12)) begin
                flag_clr[ifmu_pkg::FV_K1] = wd[0];
                flag_clr[ifmu_pkg::FV_K20] = wd[1];
            end
            if (hit(s.didx, ifmu_pkg::IDX_FLAG_CT)) begin
                flag_clr[ifmu_pkg::FV_CT +: 4] = wd;
            end
            if (hit(s.didx, ifmu_pkg::IDX_FLAG_AD)) begin
                flag_clr[ifmu_pkg::FV_AD] = wd[0];
            end
        end
    end

    ifmu_flag_bank #(
        .WIDTH(NF)
    ) u_flags (
        .hclk(hclk),
        .hresetn(hresetn),
        .set_evt(flag_set),
        .clr_w1c(flag_clr),
        .flags(flags)
    );

    assign mask_vec = {s.converter_mask, s.clock_tap_masks,
                       s.key_input20_mask, s.key_group1_mask,
                       s.key_group0_mask, s.serial_link_mask,
                       s.prog_timer_mask};

    // a flag counts only with its mask set.
    assign live = flags & mask_vec;

    // pending flags keep feeding the groups until cleared.
    assign grp = {live[ifmu_pkg::FV_AD],
                  |live[ifmu_pkg::FV_CT +: 4],
                  live[ifmu_pkg::FV_K1] | live[ifmu_pkg::FV_K20],
                  live[ifmu_pkg::FV_K0],
                  live[ifmu_pkg::FV_SIF],
                  |live[ifmu_pkg::FV_PT +: 2]};

    // The watchdog request is dropped in the cycle it is taken so the
    // registered vector never points at a request that is already gone.
    assign nmi_live = s.nmi_pend
        & ~(irq_ack & s.req & (s.vec == ifmu_pkg::VEC_WDT));

    ifmu_vector_sel #(
        .GROUPS(NG)
    ) u_sel (
        .nmi(nmi_live),
        .grp(grp),
        .any(sel_any),
        .vec(sel_vec)
    );

    always_comb begin
        next_s = s;

        // Address phase capture; hready is this slave's own hreadyout.
        if (hready) begin
            next_s.dsel = hsel & htrans[1];
            next_s.dwrite = hwrite;
            next_s.didx = haddr[ifmu_pkg::ADDR_MSB:ifmu_pkg::ADDR_LSB];
        end

        if (wr_go) begin
            // timer masks at bits 1 and 0.
            if (hit(s.didx, ifmu_pkg::IDX_MASK_PT)) begin
                next_s.prog_timer_mask = wd[1:0];
            end
            // only bit 0 is stored here.
            if (hit(s.didx, ifmu_pkg::IDX_MASK_SIF)) begin
                next_s.serial_link_mask = wd[0];
            end
            if (hit(s.didx, ifmu_pkg::IDX_MASK_K0)) begin
                next_s.key_group0_mask = wd[0];
            end
            if (hit(s.didx, ifmu_pkg::IDX_MASK_K12)) begin
                next_s.key_group1_mask = wd[0];
                next_s.key_input20_mask = wd[1];
            end
            if (hit(s.didx, ifmu_pkg::IDX_MASK_CT)) begin
                next_s.clock_tap_masks = wd;
            end
            if (hit(s.didx, ifmu_pkg::IDX_MASK_AD)) begin
                next_s.converter_mask = wd[0];
            end
            if (hit(s.didx, ifmu_pkg::IDX_WDT_CTRL)) begin
                next_s.wdt_en = wd[ifmu_pkg::WDC_ENABLE];
            end
        end

        // watchdog counts whenever enabled; restart or disable clear it.
        if (!s.wdt_en) begin
            next_s.wdt_cnt = '0;
        end else if (s.wdt_cnt == WDT_LAST) begin
            next_s.wdt_cnt = '0;
        end else begin
            next_s.wdt_cnt = s.wdt_cnt + 1'b1;
        end
        // software restart pushes the timeout back.
        if (wr_go && hit(s.didx, ifmu_pkg::IDX_WDT_CTRL)
            && wd[ifmu_pkg::WDC_RESTART]) begin
            next_s.wdt_cnt = '0;
        end

        // a second write to one pointer withdraws the other.
        if (wide_stack_pointer_wr && nibble_stack_pointer_wr) begin
            next_s.sp_wide_set = 1'b1;
            next_s.sp_nib_set = 1'b1;
        end else if (wide_stack_pointer_wr) begin
            next_s.sp_wide_set = 1'b1;
            if (s.sp_wide_set && s.sp_nib_set) begin
                next_s.sp_nib_set = 1'b0;
            end
        end else if (nibble_stack_pointer_wr) begin
            next_s.sp_nib_set = 1'b1;
            if (s.sp_wide_set && s.sp_nib_set) begin
                next_s.sp_wide_set = 1'b0;
            end
        end

        // enable or return reopens the gate for a still-set flag.
        if (ie_set || return_from_handler) begin
            next_s.ie = 1'b1;
        end
        if (ie_clr) begin
            next_s.ie = 1'b0;
        end
        next_s.nmi_pend = nmi_live;
        if (irq_ack && s.req) begin
            next_s.ie = 1'b0;
        end
        // A timeout in the same cycle as acceptance is kept pending.
        if (s.wdt_en && s.wdt_cnt == WDT_LAST) begin
            next_s.nmi_pend = 1'b1;
        end

        // nothing is requested until both pointers are written.
        next_s.req = s.sp_wide_set & s.sp_nib_set & next_s.sp_wide_set
            & next_s.sp_nib_set
            // maskable groups also need the global enable.
            & (nmi_live | (next_s.ie & (|grp)) );
        // vector of the highest pending source.
        next_s.vec = sel_any ? sel_vec : s.vec;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.prog_timer_mask <= {2{ifmu_pkg::RST_MASK}};
            s.clock_tap_masks <= {4{ifmu_pkg::RST_MASK}};
            s.wdt_en <= ifmu_pkg::RST_WDT_EN;
            s.vec <= ifmu_pkg::VEC_WDT;
        end else begin
            s <= next_s;
        end
    end

    // read mux returns zero on unimplemented bits and unmapped words.
    always_comb begin
        hrdata = '0;
        if (s.dsel && !s.dwrite) begin
            unique case (1'b1)
                hit(s.didx, ifmu_pkg::IDX_WDT_CTRL):
                    hrdata[ifmu_pkg::WDC_ENABLE] = s.wdt_en;
                hit(s.didx, ifmu_pkg::IDX_STATUS): begin
                    hrdata[ifmu_pkg::ST_SP_WIDE] = s.sp_wide_set;
                    hrdata[ifmu_pkg::ST_SP_NIBBLE] = s.sp_nib_set;
                    hrdata[ifmu_pkg::ST_IE] = s.ie;
                    hrdata[ifmu_pkg::ST_NMI] = s.nmi_pend;
                end
                hit(s.didx, ifmu_pkg::IDX_MASK_PT):
                    hrdata[1:0] = s.prog_timer_mask;
                hit(s.didx, ifmu_pkg::IDX_MASK_SIF):
                    hrdata[0] = s.serial_link_mask;
                hit(s.didx, ifmu_pkg::IDX_MASK_K0):
                    hrdata[0] = s.key_group0_mask;
                hit(s.didx, ifmu_pkg::IDX_MASK_K12):
                    hrdata[1:0] = {s.key_input20_mask, s.key_group1_mask};
                hit(s.didx, ifmu_pkg::IDX_MASK_CT):
                    hrdata[3:0] = s.clock_tap_masks;
                hit(s.didx, ifmu_pkg::IDX_MASK_AD):
                    hrdata[0] = s.converter_mask;
                hit(s.didx, ifmu_pkg::IDX_FLAG_PT):
                    hrdata[1:0] = flags[ifmu_pkg::FV_PT +: 2];
                hit(s.didx, ifmu_pkg::IDX_FLAG_SIF):
                    hrdata[0] = flags[ifmu_pkg::FV_SIF];
                hit(s.didx, ifmu_pkg::IDX_FLAG_K0):
                    hrdata[0] = flags[ifmu_pkg::FV_K0];
                hit(s.didx, ifmu_pkg::IDX_FLAG_K12):
                    hrdata[1:0] = {flags[ifmu_pkg::FV_K20],
                                   flags[ifmu_pkg::FV_K1]};
                hit(s.didx, ifmu_pkg::IDX_FLAG_CT):
                    hrdata[3:0] = flags[ifmu_pkg::FV_CT +: 4];
                hit(s.didx, ifmu_pkg::IDX_FLAG_AD):
                    hrdata[0] = flags[ifmu_pkg::FV_AD];
                default:
                    hrdata = '0;
            endcase
        end
    end

    // Zero wait states keep the slave simple; hsize is not checked.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq_req = s.req;
    assign irq_vector = s.vec;
    assign ie_flag = s.ie;
endmodule

// ==== test/ifmu_top_monitor.sv ====
// Purpose: Port checks of the interrupt flag and mask unit.
// Assumes: One clock domain; hresetn asynchronous, active low.
// Notes: The stack gate is rebuilt here from the core's pulses.
`timescale 1ns/1ps
module ifmu_top_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic wide_stack_pointer_wr,
    input wire logic nibble_stack_pointer_wr,
    input wire logic ie_set,
    input wire logic ie_clr,
    input wire logic return_from_handler,
    input wire logic irq_ack,
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic ie_flag
);
    logic sp_w;
    logic sp_n;
    logic rd_ph;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_w <= 1'b0;
            sp_n <= 1'b0;
            rd_ph <= 1'b0;
        end else begin
            sp_w <= wide_stack_pointer_wr |
                (sp_w & ~(sp_n & nibble_stack_pointer_wr));
            sp_n <= nibble_stack_pointer_wr |
                (sp_n & ~(sp_w & wide_stack_pointer_wr));
            rd_ph <= hsel & hready & htrans[1] & ~hwrite;
        end
    end
    sequence s_accept;
        irq_req && irq_ack;
    endsequence
    sequence s_quiet;
        !ie_set && !return_from_handler;
    endsequence
    property p_okay;
        hreadyout && !hresp;
    endproperty
    property p_hi_zero;
        hrdata[31:4] == 28'h0;
    endproperty
    property p_idle_zero;
        !rd_ph |-> hrdata == 32'h0;
    endproperty
    property p_gate;
        !(sp_w && sp_n) |-> !irq_req;
    endproperty
    property p_needs_ie;
        $rose(irq_req) && irq_vector != 16'h0100 |-> ie_flag;
    endproperty
    property p_ack_ie;
        (s_accept and s_quiet) |=> !ie_flag;
    endproperty
    property p_ack_drop;
        (s_accept and s_quiet) ##0 irq_vector != 16'h0100
            |=> !irq_req || irq_vector == 16'h0100;
    endproperty
    property p_ign;
        !irq_req && irq_ack && ie_flag && !ie_clr |=> ie_flag;
    endproperty
    property p_ie_on;
        ie_set && !ie_clr && !irq_ack |=> ie_flag [*2];
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus answer not ready and okay");
    a_hi_zero: assert property (p_hi_zero)
        else $error("upper read data not zero");
    a_idle_zero: assert property (p_idle_zero)
        else $error("read data outside read phase");
    a_gate: assert property (p_gate)
        else $error("request while stack gate closed");
    a_needs_ie: assert property (p_needs_ie)
        else $error("maskable request without enable");
    a_ack_ie: assert property (p_ack_ie)
        else $error("enable kept after accept");
    a_ack_drop: assert property (p_ack_drop)
        else $error("request kept after accept");
    a_ign: assert property (p_ign)
        else $error("stray accept changed enable");
    a_ie_on: assert property (p_ie_on)
        else $error("enable not set");
endmodule
bind ifmu_top ifmu_top_monitor i_mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata),
    .wide_stack_pointer_wr(wide_stack_pointer_wr),
    .nibble_stack_pointer_wr(nibble_stack_pointer_wr),
    .ie_set(ie_set), .ie_clr(ie_clr),
    .return_from_handler(return_from_handler), .irq_ack(irq_ack),
    .irq_req(irq_req), .irq_vector(irq_vector), .ie_flag(ie_flag));

// ==== test/ifmu_core_model.sv ====
// Purpose: Behavioural core that accepts interrupt requests.
// Assumes: A request is taken with a one-cycle acknowledge.
// Notes: A stray acknowledge is sent only when the bench asks.
`timescale 1ns/1ps
module ifmu_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic irq_req,
    input wire logic stray,
    output logic irq_ack,
    output int n_acc
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ack <= 1'b0;
            n_acc <= 0;
        end else begin
            irq_ack <= (irq_req & ~irq_ack) | stray;
            if (irq_ack && irq_req) begin
                n_acc <= n_acc + 1;
            end
        end
    end
endmodule

// ==== test/test_interrupt_flag_mask_unit.sv ====
// Purpose: Register and request checks of the interrupt flag unit.
// Assumes: Zero-wait slave; watchdog shortened to 64 cycles.
// Notes: Read data is sampled just before the closing edge.
`timescale 1ns/1ps
module test_interrupt_flag_mask_unit;
    localparam int unsigned WDT = 64;
    localparam logic [15:0] MIDX [6] = '{16'hffe2, 16'hffe3, 16'hffe4,
        16'hffe5, 16'hffe6, 16'hffe7};
    localparam logic [3:0] IMP [6] = '{4'h3, 4'h1, 4'h1, 4'h3, 4'hf, 4'h1};
    localparam logic [15:0] WDC = ifmu_pkg::IDX_WDT_CTRL;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [10:0] evt = 11'h0;
    logic [4:0] cs = 5'h0;
    logic stray = 1'b0;
    logic coin = 1'b0;
    logic seen = 1'b0;
    logic hreadyout, hresp, irq_ack, irq_req, ie_flag;
    logic [31:0] hrdata;
    logic [15:0] irq_vector, vec;
    int n_acc, cyc = 0, n_mismatch = 0, cmp_count = 0;
    ifmu_top #(.WDT_CYCLES(WDT)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .prog_timer_evt(evt[1:0]),
        .serial_link_evt(evt[2]), .key_group0_evt(evt[3]),
        .key_group1_evt(evt[4]), .key_input20_evt(evt[5]),
        .clock_tap_evt(evt[9:6]), .converter_evt(evt[10]),
        .wide_stack_pointer_wr(cs[0]), .nibble_stack_pointer_wr(cs[1]),
        .ie_set(cs[2]), .ie_clr(cs[3]), .return_from_handler(cs[4]),
        .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector),
        .ie_flag(ie_flag));
    ifmu_core_model i_core (.hclk(hclk), .hresetn(hresetn),
        .irq_req(irq_req), .stray(stray), .irq_ack(irq_ack), .n_acc(n_acc));
    always #2 hclk = ~hclk;
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    // Sampling on the falling edge keeps reads clear of update races.
    task automatic xfer(logic [15:0] idx, logic w, logic [3:0] d,
                        output logic [31:0] rd);
        logic rdy;
        hsel <= 1'b1;
        haddr <= {14'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        do begin
            @(negedge hclk);
            rdy = hreadyout;
            @(posedge hclk);
        end while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {28'h0, d};
        if (coin) evt[10] <= 1'b1;
        do begin
            @(negedge hclk);
            rdy = hreadyout;
            rd = hrdata;
            @(posedge hclk);
        end while (rdy !== 1'b1);
        if (coin) evt[10] <= 1'b0;
    endtask
    task automatic wr(logic [15:0] idx, logic [3:0] d);
        logic [31:0] x;
        xfer(idx, 1'b1, d, x);
    endtask
    task automatic rdc(logic [15:0] idx, logic [3:0] e, string what);
        logic [31:0] x;
        xfer(idx, 1'b0, 4'h0, x);
        chk(what, {28'h0, e}, x);
    endtask
    task automatic pulse(logic [10:0] v, logic [4:0] c);
        evt <= v;
        cs <= c;
        @(posedge hclk);
        evt <= 11'h0;
        cs <= 5'h0;
        @(posedge hclk);
    endtask
    task automatic wait_req(int n);
        seen = 1'b0;
        vec = 16'hxxxx;
        for (int i = 0; i < n && !seen; i++) begin
            @(negedge hclk);
            seen = (irq_req === 1'b1);
            vec = irq_vector;
            @(posedge hclk);
        end
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 6; i++) begin
            rdc(MIDX[i], 4'h0, "mask reset");
            rdc(MIDX[i] + 16'h10, 4'h0, "flag reset");
        end
        rdc(WDC, 4'h1, "watchdog reset");
        repeat (WDT + 8) @(posedge hclk);
        rdc(ifmu_pkg::IDX_STATUS, 4'h8, "status");
        wr(WDC, 4'h0);
        pulse(11'h7ff, 5'h0);
        for (int i = 0; i < 6; i++) begin
            wr(MIDX[i] + 16'h10, 4'h0);
            rdc(MIDX[i] + 16'h10, IMP[i], "flags");
            wr(MIDX[i], 4'hf);
            rdc(MIDX[i], IMP[i], "masks");
        end
        wr(16'hfff0, 4'hf);
        rdc(16'hfff0, 4'h0, "unmapped");
        pulse(11'h0, 5'h04);
        wait_req(20);
        chk("gate shut", 32'h0, {31'h0, seen});
        pulse(11'h0, 5'h01);
        wait_req(20);
        chk("gate half", 32'h0, {31'h0, seen});
        pulse(11'h0, 5'h02);
        wait_req(20);
        chk("nmi vector", 32'h10100, {15'h0, seen, vec});
        // An enable pulse on the acceptance edge would be overridden.
        repeat (3) @(posedge hclk);
        for (int g = 0; g < 6; g++) begin
            for (int k = 0; k < 2; k++) begin
                pulse(11'h0, k == 0 ? 5'h04 : 5'h10);
                wait_req(20);
                chk("vector", 32'h10104 + 2 * g,
                    {15'h0, seen, vec});
                repeat (3) @(posedge hclk);
                chk("ie after ack", 32'h0, {31'h0, ie_flag});
            end
            wr(MIDX[g] + 16'h10, 4'hf);
            rdc(MIDX[g] + 16'h10, 4'h0, "cleared");
        end
        coin = 1'b1;
        wr(16'hfff7, 4'h1);
        coin = 1'b0;
        rdc(16'hfff7, 4'h1, "event vs clear");
        wait_req(20);
        chk("ie off", 32'h0, {31'h0, seen});
        wr(16'hffe7, 4'h0);
        pulse(11'h0, 5'h04);
        wait_req(20);
        chk("mask off", 32'h0, {31'h0, seen});
        stray <= 1'b1;
        @(posedge hclk);
        stray <= 1'b0;
        @(posedge hclk);
        @(negedge hclk);
        chk("stray ack", 32'h1, {31'h0, ie_flag});
        @(posedge hclk);
        pulse(11'h0, 5'h01);
        wr(16'hffe7, 4'h1);
        wait_req(20);
        chk("rewrite gate", 32'h0, {31'h0, seen});
        pulse(11'h0, 5'h02);
        wait_req(20);
        chk("gate reopened", 32'h1010e, {15'h0, seen, vec});
        wr(16'hfff7, 4'h1);
        wr(WDC, 4'h3);
        for (int i = 0; i < 4; i++) begin
            wait_req(40);
            chk("serviced", 32'h0, {31'h0, seen});
            wr(WDC, 4'h3);
        end
        wait_req(100);
        chk("watchdog", 32'h10100, {15'h0, seen, vec});
        wr(WDC, 4'h0);
        repeat (4) @(posedge hclk);
        chk("accepted", 32'd15, n_acc);
        finish_test();
    end
endmodule
